// ### logic/mmd_memory_decoder.sv
`timescale 1ns/1ns
module mmd_memory_decoder
  import mmd_pkg::*;
#(
  parameter mmd_variant_t VARIANT = MMD_VAR_32K,
  parameter int KEY_W = 256
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // cpu master
  input wire logic cpu_req_i,
  input wire logic cpu_we_i,
  input wire logic cpu_byte_i,
  input wire logic cpu_fetch_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [15:0] cpu_wdata_i,
  // debug port master
  input wire logic dbg_req_i,
  input wire logic dbg_we_i,
  input wire logic dbg_byte_i,
  input wire logic [15:0] dbg_addr_i,
  input wire logic [15:0] dbg_wdata_i,
  // serial boot loader master
  input wire logic bl_req_i,
  input wire logic bl_we_i,
  input wire logic bl_byte_i,
  input wire logic [15:0] bl_addr_i,
  input wire logic [15:0] bl_wdata_i,
  input wire logic bl_key_vld_i,
  input wire logic [KEY_W-1:0] bl_key_i,
  input wire logic [KEY_W-1:0] key_ref_i,
  // serial boot loader link
  input wire logic bl_txd_i,
  input wire logic bl_rxd_pin_i,
  output logic bl_txd_pin_o,
  output logic bl_rxd_o,
  output logic bl_open_o,
  output logic bl_key_bad_o,
  // erase control
  input wire logic ers_req_i,
  input wire mmd_erase_t ers_mode_i,
  input wire logic [15:0] ers_addr_i,
  input wire logic seg_a_unlock_i,
  // grants
  output logic cpu_gnt_o,
  output logic dbg_gnt_o,
  output logic bl_gnt_o,
  // decoded bus
  output logic bus_vld_o,
  output logic bus_we_o,
  output logic bus_byte_o,
  output logic [15:0] bus_addr_o,
  output logic [15:0] bus_wdata_o,
  output logic sel_sfa_o,
  output logic sel_per8_o,
  output logic sel_per16_o,
  output logic sel_ram_o,
  output logic sel_boot_o,
  output logic sel_info_o,
  output logic sel_main_o,
  output logic sel_vec_o,
  output logic sel_cal_o,
  output logic [7:0] sfa_wmask_o,
  // information flash read
  output logic [15:0] info_rdata_o,
  output logic info_rvld_o,
  // main flash erase
  output logic main_ers_o,
  output logic main_ers_all_o,
  output logic [5:0] main_ers_seg_o,
  // faults
  output logic lock_viol_o,
  output logic fetch_rst_o
);

  localparam logic [15:0] MAIN_LO = mmd_main_lo(VARIANT);

  mmd_master_t m_sel;
  logic any_gnt;
  logic bl_req_ok;
  logic m_we;
  logic m_byte;
  logic [15:0] m_addr;
  logic [15:0] m_wdata;
  mmd_region_t m_rg;
  mmd_region_t e_rg;
  logic acc_ok;
  logic info_acc;
  logic seg_a_hit;
  logic info_wr;
  logic info_rd;
  logic [1:0] info_be;
  logic [3:0] info_ers;
  logic a_viol;
  logic [6:0] seg_diff;
  logic seg_a_open_r;
  logic key_match_r;
  mmd_bl_state_t bl_st_r;
  logic [2:0] rxd_sync_r;

  // R17 boot loader requests pass only once the password opened it
  assign bl_req_ok = bl_req_i && (bl_st_r == MMD_BL_OPEN);

  mmd_master_arb u_arb (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .req_cpu_i(cpu_req_i),
    .req_dbg_i(dbg_req_i),
    .req_bl_i(bl_req_ok),
    .gnt_cpu_o(cpu_gnt_o),
    .gnt_dbg_o(dbg_gnt_o),
    .gnt_bl_o(bl_gnt_o),
    .sel_o(m_sel)
  );

  assign any_gnt = cpu_gnt_o || dbg_gnt_o || bl_gnt_o;

  // R15 every master shares the one address and data path
  assign m_we = (m_sel == MMD_M_DBG) ? dbg_we_i : ((m_sel == MMD_M_BL) ? bl_we_i : cpu_we_i);
  assign m_byte = (m_sel == MMD_M_DBG) ? dbg_byte_i : ((m_sel == MMD_M_BL) ? bl_byte_i : cpu_byte_i);
  assign m_addr = (m_sel == MMD_M_DBG) ? dbg_addr_i : ((m_sel == MMD_M_BL) ? bl_addr_i : cpu_addr_i);
  assign m_wdata = (m_sel == MMD_M_DBG) ? dbg_wdata_i : ((m_sel == MMD_M_BL) ? bl_wdata_i : cpu_wdata_i);

  // R06 region decode
  assign m_rg = mmd_region(m_addr, VARIANT);
  assign e_rg = mmd_region(ers_addr_i, VARIANT);

  // R16 boot loader reaches flash and RAM only
  assign acc_ok = any_gnt && !(bl_gnt_o && !(m_rg == MMD_RG_RAM || m_rg == MMD_RG_INFO || m_rg == MMD_RG_MAIN));

  // R13 segment A lock, closed again by any reset
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seg_a_open_r <= 1'b0;
    end else begin
      seg_a_open_r <= seg_a_unlock_i;
    end
  end

  assign info_acc = acc_ok && (m_rg == MMD_RG_INFO);
  // R10 segment index from address bits 7:6
  assign seg_a_hit = m_addr[7:MMD_INFO_SEG_SHIFT] == MMD_INFO_SEG_A;
  // R13 programming of locked segment A is dropped
  assign info_wr = info_acc && m_we && !(seg_a_hit && !seg_a_open_r);
  assign info_rd = info_acc && !m_we;

  // R08 byte lane pick, word writes use both lanes
  always_comb begin
    info_be = 2'b00;
    if (info_wr) begin
      if (!m_byte) info_be = 2'b11;
      else if (m_addr[0]) info_be = 2'b10;
      else info_be = 2'b01;
    end
  end

  // R12 individual info erase or group with the main array
  always_comb begin
    info_ers = 4'h0;
    if (ers_req_i) begin
      unique case (ers_mode_i)
        MMD_ERS_SEG: begin
          if (e_rg == MMD_RG_INFO) info_ers[ers_addr_i[7:MMD_INFO_SEG_SHIFT]] = 1'b1;
        end
        MMD_ERS_ALL: info_ers = MMD_INFO_ALL;
        default: info_ers = 4'h0;
      endcase
    end
    // R13 erase of locked segment A refused
    if (!seg_a_open_r) info_ers[MMD_INFO_SEG_A] = 1'b0;
  end

  mmd_info_mem #(
    .WORDS(128),
    .AW(7),
    .SEGS(4)
  ) u_info (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .rd_i(info_rd),
    .idx_i(m_addr[7:1]),
    .be_i(info_be),
    .wdata_i(m_byte ? {m_wdata[7:0], m_wdata[7:0]} : m_wdata),
    .ers_seg_i(info_ers),
    .rdata_o(info_rdata_o)
  );

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      info_rvld_o <= 1'b0;
    end else begin
      info_rvld_o <= info_rd;
    end
  end

  // registered decoded bus towards RAM, peripherals and main flash
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_vld_o <= 1'b0;
      bus_we_o <= 1'b0;
      bus_byte_o <= 1'b0;
      bus_addr_o <= 16'h0000;
      bus_wdata_o <= 16'h0000;
    end else begin
      bus_vld_o <= acc_ok;
      // R20 boot memory is read-only
      bus_we_o <= acc_ok && m_we && (m_rg != MMD_RG_BOOT);
      bus_byte_o <= m_byte;
      bus_addr_o <= m_addr;
      bus_wdata_o <= m_wdata;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_sfa_o <= 1'b0;
      sel_per8_o <= 1'b0;
      sel_per16_o <= 1'b0;
      sel_ram_o <= 1'b0;
      sel_boot_o <= 1'b0;
      sel_info_o <= 1'b0;
      sel_main_o <= 1'b0;
      sel_vec_o <= 1'b0;
      sel_cal_o <= 1'b0;
      sfa_wmask_o <= 8'h00;
    end else begin
      // R06 peripheral and special function area selects
      sel_sfa_o <= acc_ok && (m_rg == MMD_RG_SFA);
      sel_per8_o <= acc_ok && (m_rg == MMD_RG_PER8);
      sel_per16_o <= acc_ok && (m_rg == MMD_RG_PER16);
      // R05 RAM window
      sel_ram_o <= acc_ok && (m_rg == MMD_RG_RAM);
      // R04 boot memory window
      sel_boot_o <= acc_ok && (m_rg == MMD_RG_BOOT);
      // R03 information flash window
      sel_info_o <= info_acc;
      // R02 main flash window
      sel_main_o <= acc_ok && (m_rg == MMD_RG_MAIN);
      // R01 vector table at the top of main flash
      sel_vec_o <= acc_ok && (m_rg == MMD_RG_MAIN) && (m_addr >= MMD_VEC_LO);
      // R14 calibration bytes at the top of segment A
      sel_cal_o <= info_acc && (m_addr >= MMD_CAL_LO);
      // R19 unassigned bits carry no storage
      sfa_wmask_o <= (acc_ok && m_rg == MMD_RG_SFA) ? mmd_sfa_mask(m_addr) : 8'h00;
    end
  end

  // R09 512-byte segment number counted from the bottom of main flash
  assign seg_diff = 7'(ers_addr_i[15:MMD_MAIN_SEG_SHIFT] - MAIN_LO[15:MMD_MAIN_SEG_SHIFT]);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      main_ers_o <= 1'b0;
      main_ers_all_o <= 1'b0;
      main_ers_seg_o <= 6'h00;
    end else begin
      // R11 mass erase or single segment erase
      main_ers_o <= ers_req_i && (ers_mode_i != MMD_ERS_SEG || e_rg == MMD_RG_MAIN);
      main_ers_all_o <= ers_req_i && (ers_mode_i == MMD_ERS_MAIN || ers_mode_i == MMD_ERS_ALL);
      main_ers_seg_o <= seg_diff[5:0];
    end
  end

  // R13 flag refused program or single segment erase of segment A
  assign a_viol = (info_acc && m_we && seg_a_hit && !seg_a_open_r)
    || (ers_req_i && ers_mode_i == MMD_ERS_SEG && e_rg == MMD_RG_INFO
        && ers_addr_i[7:MMD_INFO_SEG_SHIFT] == MMD_INFO_SEG_A && !seg_a_open_r);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_viol_o <= 1'b0;
    end else begin
      lock_viol_o <= a_viol;
    end
  end

  // R18 fetch from register space or a hole resets the device
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fetch_rst_o <= 1'b0;
    end else begin
      fetch_rst_o <= cpu_gnt_o && cpu_fetch_i && (m_rg == MMD_RG_NONE || m_rg == MMD_RG_SFA
        || m_rg == MMD_RG_PER8 || m_rg == MMD_RG_PER16);
    end
  end

  // R17 password check, one cycle to register the wide compare
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bl_st_r <= MMD_BL_LOCKED;
      key_match_r <= 1'b0;
      bl_key_bad_o <= 1'b0;
    end else begin
      bl_key_bad_o <= 1'b0;
      unique case (bl_st_r)
        MMD_BL_LOCKED: begin
          if (bl_key_vld_i) begin
            key_match_r <= (bl_key_i == key_ref_i);
            bl_st_r <= MMD_BL_CHECK;
          end
        end
        MMD_BL_CHECK: begin
          bl_st_r <= key_match_r ? MMD_BL_OPEN : MMD_BL_LOCKED;
          bl_key_bad_o <= !key_match_r;
        end
        MMD_BL_OPEN: bl_st_r <= MMD_BL_OPEN;
        default: bl_st_r <= MMD_BL_LOCKED;
      endcase
    end
  end

  assign bl_open_o = (bl_st_r == MMD_BL_OPEN);

  // R16 serial link pins; receive line is asynchronous
  // a level is taken only when stages two and three agree
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rxd_sync_r <= 3'b111;
      bl_rxd_o <= 1'b1;
      bl_txd_pin_o <= 1'b1;
    end else begin
      rxd_sync_r <= {rxd_sync_r[1:0], bl_rxd_pin_i};
      if (rxd_sync_r[1] == rxd_sync_r[2]) bl_rxd_o <= rxd_sync_r[2];
      bl_txd_pin_o <= bl_txd_i;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_key_good;
    bl_key_vld_i && (bl_key_i == key_ref_i) && (bl_st_r == MMD_BL_LOCKED);
  endsequence
  sequence s_key_bad;
    bl_key_vld_i && (bl_key_i != key_ref_i) && (bl_st_r == MMD_BL_LOCKED);
  endsequence
  chk_key_opens: assert property (s_key_good |-> ##2 bl_open_o) // R17
    else $error("correct password did not open boot loader");
  chk_key_refused: assert property (s_key_bad |-> ##2 (bl_key_bad_o && !bl_open_o)) // R17
    else $error("wrong password not refused");
  chk_bl_gated: assert property (bl_gnt_o |-> bl_open_o) // R17
    else $error("boot loader granted while locked");
  chk_fetch_reset: assert property (
    (cpu_gnt_o && cpu_fetch_i && cpu_addr_i <= MMD_PER16_HI) |=> fetch_rst_o) // R18
    else $error("fetch from register space gave no reset");
  chk_boot_nowrite: assert property ((bus_vld_o && sel_boot_o) |-> !bus_we_o) // R20
    else $error("write reached boot memory");
  chk_vec_window: assert property (sel_vec_o |-> (sel_main_o && bus_addr_o >= MMD_VEC_LO)) // R01
    else $error("vector select outside vector table");
  chk_main_window: assert property (sel_main_o |-> bus_addr_o >= MAIN_LO) // R02
    else $error("main flash select below its base");
  chk_ram_window: assert property (
    sel_ram_o |-> (bus_addr_o >= MMD_RAM_LO && bus_addr_o <= mmd_ram_hi(VARIANT))) // R05
    else $error("RAM select outside RAM");
  chk_info_window: assert property (
    sel_info_o |-> (bus_addr_o >= MMD_INFO_LO && bus_addr_o <= MMD_INFO_HI)) // R03
    else $error("info select outside info flash");
  chk_sfa_holes: assert property ((sel_sfa_o && bus_addr_o > 16'h0003) |-> sfa_wmask_o == 8'h00) // R19
    else $error("storage behind unassigned special bit");
  chk_seg_a_lock: assert property (
    (info_acc && m_we && seg_a_hit && !seg_a_open_r) |-> (info_be == 2'b00) ##1 lock_viol_o) // R13
    else $error("locked segment A was programmed");
  chk_mass_erase: assert property (
    (ers_req_i && ers_mode_i == MMD_ERS_MAIN) |=> (main_ers_o && main_ers_all_o)) // R11
    else $error("mass erase not issued");
  chk_info_rvld: assert property (info_rd |=> info_rvld_o ##1 !info_rvld_o || $past(info_rd)) // R03
    else $error("info read valid misplaced");

endmodule

// ### logic/mmd_pkg.sv
// Function
// R01: vector table sits in main flash at 0ffc0h to 0ffffh on every variant.
// R02: main flash ends at 0ffffh, starts at 0e000h, 0c000h or 08000h by variant.
// R03: 256 bytes of information flash decode at 01000h to 010ffh.
// R04: 1KB read-only boot memory decodes at 0c00h to 0fffh.
// R05: RAM starts at 0200h, ends 03ffh on small variants, 05ffh on largest.
// R06: word peripherals 0100h-01ffh, byte peripherals 010h-0ffh, special function area 00h-0fh.
// R07: flash is programmable by debug port, serial boot loader and the CPU.
// R08: CPU flash writes may be single bytes or single 16-bit words.
// R09: main flash erases in 512-byte segments numbered from zero upward.
// R10: information flash has four 64-byte segments, A to D.
// R11: main segments erase all together or one segment alone.
// R12: information segments erase alone, or all together with the main array.
// R13: after reset segment A refuses program and erase until software unlocks it.
// R14: oscillator calibration bytes occupy 010f8h to 010ffh inside segment A.
// R15: peripheral registers sit on the shared bus, reachable like plain memory.
// R16: external host programs flash or RAM through the boot loader's serial link.
// R17: the boot loader grants memory access only after a correct password.
// R18: CPU fetch from 0h-01ffh or unused space raises a reset.
// R19: unassigned special function area bits have no storage behind them.
// R20: writes aimed at boot memory are dropped and leave it unchanged.
package mmd_pkg;

  localparam logic [15:0] MMD_SFA_LO = 16'h0000;
  localparam logic [15:0] MMD_SFA_HI = 16'h000f;
  localparam logic [15:0] MMD_PER8_HI = 16'h00ff;
  localparam logic [15:0] MMD_PER16_HI = 16'h01ff;
  localparam logic [15:0] MMD_RAM_LO = 16'h0200;
  localparam logic [15:0] MMD_RAM_HI_SMALL = 16'h03ff;
  localparam logic [15:0] MMD_RAM_HI_LARGE = 16'h05ff;
  localparam logic [15:0] MMD_BOOT_LO = 16'h0c00;
  localparam logic [15:0] MMD_BOOT_HI = 16'h0fff;
  localparam logic [15:0] MMD_INFO_LO = 16'h1000;
  localparam logic [15:0] MMD_INFO_HI = 16'h10ff;
  localparam logic [15:0] MMD_CAL_LO = 16'h10f8;
  localparam logic [15:0] MMD_MAIN_LO_8K = 16'he000;
  localparam logic [15:0] MMD_MAIN_LO_16K = 16'hc000;
  localparam logic [15:0] MMD_MAIN_LO_32K = 16'h8000;
  localparam logic [15:0] MMD_VEC_LO = 16'hffc0;
  localparam int MMD_MAIN_SEG_SHIFT = 9;
  localparam int MMD_INFO_SEG_SHIFT = 6;
  localparam logic [1:0] MMD_INFO_SEG_A = 2'h3;
  localparam logic [3:0] MMD_INFO_ALL = 4'hf;
  localparam logic [15:0] MMD_ERASED = 16'hffff;
  localparam logic [7:0] MMD_SFA_MASK_0 = 8'h33;
  localparam logic [7:0] MMD_SFA_MASK_1 = 8'h0f;
  localparam logic [7:0] MMD_SFA_MASK_2 = 8'h1f;
  localparam logic [7:0] MMD_SFA_MASK_3 = 8'h0f;

  typedef enum logic [1:0] {
    MMD_VAR_8K = 2'h0,
    MMD_VAR_16K = 2'h1,
    MMD_VAR_32K = 2'h2
  } mmd_variant_t;

  typedef enum logic [3:0] {
    MMD_RG_NONE = 4'h0,
    MMD_RG_SFA = 4'h1,
    MMD_RG_PER8 = 4'h2,
    MMD_RG_PER16 = 4'h3,
    MMD_RG_RAM = 4'h4,
    MMD_RG_BOOT = 4'h5,
    MMD_RG_INFO = 4'h6,
    MMD_RG_MAIN = 4'h7
  } mmd_region_t;

  typedef enum logic [1:0] {
    MMD_ERS_SEG = 2'h0,
    MMD_ERS_MAIN = 2'h1,
    MMD_ERS_ALL = 2'h2
  } mmd_erase_t;

  typedef enum logic [1:0] {
    MMD_M_CPU = 2'h0,
    MMD_M_DBG = 2'h1,
    MMD_M_BL = 2'h2
  } mmd_master_t;

  typedef enum logic [1:0] {
    MMD_BL_LOCKED = 2'b00,
    MMD_BL_CHECK = 2'b01,
    MMD_BL_OPEN = 2'b11
  } mmd_bl_state_t;

  function automatic logic [15:0] mmd_main_lo(input mmd_variant_t v);
    case (v)
      MMD_VAR_8K: mmd_main_lo = MMD_MAIN_LO_8K;
      MMD_VAR_16K: mmd_main_lo = MMD_MAIN_LO_16K;
      default: mmd_main_lo = MMD_MAIN_LO_32K;
    endcase
  endfunction

  function automatic logic [15:0] mmd_ram_hi(input mmd_variant_t v);
    mmd_ram_hi = (v == MMD_VAR_32K) ? MMD_RAM_HI_LARGE : MMD_RAM_HI_SMALL;
  endfunction

  function automatic mmd_region_t mmd_region(input logic [15:0] a, input mmd_variant_t v);
    if (a <= MMD_SFA_HI) mmd_region = MMD_RG_SFA;
    else if (a <= MMD_PER8_HI) mmd_region = MMD_RG_PER8;
    else if (a <= MMD_PER16_HI) mmd_region = MMD_RG_PER16;
    else if (a >= MMD_RAM_LO && a <= mmd_ram_hi(v)) mmd_region = MMD_RG_RAM;
    else if (a >= MMD_BOOT_LO && a <= MMD_BOOT_HI) mmd_region = MMD_RG_BOOT;
    else if (a >= MMD_INFO_LO && a <= MMD_INFO_HI) mmd_region = MMD_RG_INFO;
    else if (a >= mmd_main_lo(v)) mmd_region = MMD_RG_MAIN;
    else mmd_region = MMD_RG_NONE;
  endfunction

  // only the first four bytes of the area hold real bits
  function automatic logic [7:0] mmd_sfa_mask(input logic [15:0] a);
    case (a)
      16'h0000: mmd_sfa_mask = MMD_SFA_MASK_0;
      16'h0001: mmd_sfa_mask = MMD_SFA_MASK_1;
      16'h0002: mmd_sfa_mask = MMD_SFA_MASK_2;
      16'h0003: mmd_sfa_mask = MMD_SFA_MASK_3;
      default: mmd_sfa_mask = 8'h00;
    endcase
  endfunction

endpackage

// ### logic/mmd_master_arb.sv
`timescale 1ns/1ns
module mmd_master_arb
  import mmd_pkg::*;
(
  // clock, reset and requests
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic req_cpu_i,
  input wire logic req_dbg_i,
  input wire logic req_bl_i,
  // grants
  output logic gnt_cpu_o,
  output logic gnt_dbg_o,
  output logic gnt_bl_o,
  output mmd_master_t sel_o
);

  // R07 three programming masters
  // debug port wins so a halted core can always be reached
  always_comb begin
    gnt_dbg_o = req_dbg_i;
    gnt_bl_o = req_bl_i && !req_dbg_i;
    gnt_cpu_o = req_cpu_i && !req_dbg_i && !req_bl_i;
    if (req_dbg_i) sel_o = MMD_M_DBG;
    else if (req_bl_i) sel_o = MMD_M_BL;
    else sel_o = MMD_M_CPU;
  end

  // R07 one master at a time
  chk_single_grant: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // R07
    $onehot0({gnt_cpu_o, gnt_dbg_o, gnt_bl_o}) && ((req_cpu_i || req_dbg_i || req_bl_i)
      == (gnt_cpu_o || gnt_dbg_o || gnt_bl_o)))
    else $error("grant not one-hot or request left unserved");

endmodule

// ### logic/mmd_info_mem.sv
`timescale 1ns/1ns
module mmd_info_mem
  import mmd_pkg::*;
#(
  parameter int WORDS = 128,
  parameter int AW = 7,
  parameter int SEGS = 4
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // access
  input wire logic rd_i,
  input wire logic [AW-1:0] idx_i,
  input wire logic [1:0] be_i,
  input wire logic [15:0] wdata_i,
  input wire logic [SEGS-1:0] ers_seg_i,
  // read data
  output logic [15:0] rdata_o
);

  localparam int SEG_WORDS = WORDS / SEGS;

  logic [15:0] mem [WORDS];

  // flash keeps its contents through reset, so no reset here
  always_ff @(posedge ref_clk_i) begin
    // R08 byte or word programming, bits only clear
    if (be_i[0]) mem[idx_i][7:0] <= mem[idx_i][7:0] & wdata_i[7:0];
    if (be_i[1]) mem[idx_i][15:8] <= mem[idx_i][15:8] & wdata_i[15:8];
    // R10 erase per 64-byte segment
    for (int i = 0; i < WORDS; i++) begin
      if (ers_seg_i[i / SEG_WORDS]) mem[i] <= MMD_ERASED;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      rdata_o <= mem[idx_i];
    end
  end

endmodule

// ### test/mmd_bl_host.sv
`timescale 1ns/1ns
module mmd_bl_host (
  // control from bench
  input wire logic ref_clk_i,
  input wire logic go_i,
  input wire logic good_i,
  input wire logic rxd_lvl_i,
  input wire logic [255:0] key_ref_i,
  // toward boot loader
  output logic key_vld_o,
  output logic [255:0] key_o,
  output logic rxd_pin_o
);
  initial begin
    key_vld_o = 1'b0;
    key_o = '0;
  end
  always @(posedge ref_clk_i) begin
    key_vld_o <= go_i;
    // stale key is inverted every cycle, so it matches key_ref_i on alternate cycles
    key_o <= go_i ? (good_i ? key_ref_i : ~key_ref_i) : ~key_o;
  end
  assign rxd_pin_o = rxd_lvl_i;
endmodule

// ### test/tb.sv
`timescale 1ns/1ns
module tb;
  import mmd_pkg::*;
  logic ref_clk_i, nrst_i, c_req, c_we, c_by, c_f, d_req, b_req, txd, ers, unl, go, good, rxl;
  logic [15:0] c_a, c_d, b_a, e_a;
  mmd_erase_t e_m;
  logic [255:0] kref = {8{32'h5a3c96e1}};
  wire [255:0] key;
  wire kv, rxp, rxo, txo, opn, kbad, cg, dg, bg, vld, we, bby, rv, me, mall, lv, frst;
  wire s_sfa, s_p8, s_p16, s_ram, s_bt, s_inf, s_mn, s_vec, s_cal;
  wire [15:0] rd, ba, bwd;
  wire [5:0] mseg;
  wire [7:0] msk;
  wire [15:0] sel = {7'h0, s_sfa, s_p8, s_p16, s_ram, s_bt, s_inf, s_mn, s_vec, s_cal};
  int mismatches, comparisons, i;
  localparam logic [15:0] AD [18] = '{16'h0000, 16'h000f, 16'h0010, 16'h00ff, 16'h0100, 16'h01ff,
    16'h0200, 16'h05ff, 16'h0600, 16'h0c00, 16'h0fff, 16'h1000, 16'h10f7, 16'h10f8, 16'h7fff,
    16'h8000, 16'hffbf, 16'hffc0};
  localparam logic [15:0] EX [18] = '{16'h100, 16'h100, 16'h080, 16'h080, 16'h040, 16'h040,
    16'h020, 16'h020, 16'h000, 16'h010, 16'h010, 16'h008, 16'h008, 16'h009, 16'h000,
    16'h004, 16'h004, 16'h006};
  mmd_bl_host host_u (.ref_clk_i, .go_i(go), .good_i(good), .rxd_lvl_i(rxl), .key_ref_i(kref),
    .key_vld_o(kv), .key_o(key), .rxd_pin_o(rxp));
  mmd_memory_decoder dut_u (.ref_clk_i, .nrst_i, .cpu_req_i(c_req), .cpu_we_i(c_we),
    .cpu_byte_i(c_by), .cpu_fetch_i(c_f), .cpu_addr_i(c_a), .cpu_wdata_i(c_d), .dbg_req_i(d_req),
    .dbg_we_i(c_we), .dbg_byte_i(c_by), .dbg_addr_i(c_a), .dbg_wdata_i(c_d), .bl_req_i(b_req),
    .bl_we_i(1'b1), .bl_byte_i(1'b0), .bl_addr_i(b_a), .bl_wdata_i(c_d), .bl_key_vld_i(kv),
    .bl_key_i(key), .key_ref_i(kref), .bl_txd_i(txd), .bl_rxd_pin_i(rxp), .bl_txd_pin_o(txo),
    .bl_rxd_o(rxo), .bl_open_o(opn), .bl_key_bad_o(kbad), .ers_req_i(ers), .ers_mode_i(e_m),
    .ers_addr_i(e_a), .seg_a_unlock_i(unl), .cpu_gnt_o(cg), .dbg_gnt_o(dg), .bl_gnt_o(bg),
    .bus_vld_o(vld), .bus_we_o(we), .bus_byte_o(bby), .bus_addr_o(ba), .bus_wdata_o(bwd),
    .sel_sfa_o(s_sfa), .sel_per8_o(s_p8), .sel_per16_o(s_p16), .sel_ram_o(s_ram),
    .sel_boot_o(s_bt), .sel_info_o(s_inf), .sel_main_o(s_mn), .sel_vec_o(s_vec),
    .sel_cal_o(s_cal), .sfa_wmask_o(msk), .info_rdata_o(rd), .info_rvld_o(rv), .main_ers_o(me),
    .main_ers_all_o(mall), .main_ers_seg_o(mseg), .lock_viol_o(lv), .fetch_rst_o(frst));
  task tick;
    @(posedge ref_clk_i);
    #1;
  endtask
  task chk(input logic [15:0] g, e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chkb(input logic g, e);
    chk({15'h0, g}, {15'h0, e});
  endtask
  task acc(input logic f, w, by, input logic [15:0] a, d);
    tick;
    c_req = 1;
    c_f = f;
    c_we = w;
    c_by = by;
    c_a = a;
    c_d = d;
    tick;
    c_req = 0;
  endtask
  task ersq(input mmd_erase_t m, input logic [15:0] a);
    tick;
    ers = 1;
    e_m = m;
    e_a = a;
    tick;
    ers = 0;
  endtask
  task t_map;
    for (i = 0; i < 18; i++) begin
      acc(0, 0, 0, AD[i], 0);
      chk(sel, EX[i]);
      chk(ba, AD[i]);
      chkb(vld, 1);
    end
  endtask
  task t_misc;
    acc(1, 0, 0, 16'h0100, 0);
    chkb(frst, 1);
    acc(1, 0, 0, 16'h0800, 0);
    chkb(frst, 1);
    acc(1, 0, 0, 16'h8000, 0);
    chkb(frst, 0);
    acc(0, 1, 1, 16'h0000, 16'h00ff);
    chk({8'h0, msk}, 16'h0033);
    chkb(bby, 1);
    chk(bwd, 16'h00ff);
    acc(0, 1, 1, 16'h0004, 16'h00ff);
    chk({8'h0, msk}, 16'h0000);
    acc(0, 1, 0, 16'h0c00, 16'h1234);
    chkb(we, 0);
    chkb(bby, 0);
    chk(sel, 16'h010);
    tick;
    c_req = 1;
    d_req = 1;
    c_a = 16'h0200;
    #1;
    chk({cg, dg}, 2'b01);
    tick;
    chk(sel, 16'h020);
    c_req = 0;
    d_req = 0;
  endtask
  task t_lock;
    unl = 1;
    ersq(MMD_ERS_SEG, 16'h10c0);
    acc(0, 1, 1, 16'h10c1, 16'h0000);
    chkb(lv, 0);
    acc(0, 0, 0, 16'h10c0, 0);
    chk(rd, 16'h00ff);
    chkb(rv, 1);
    unl = 0;
    acc(0, 1, 0, 16'h10c0, 16'h0000);
    chkb(lv, 1);
    ersq(MMD_ERS_SEG, 16'h10c0);
    chkb(lv, 1);
    acc(0, 0, 0, 16'h10c0, 0);
    chk(rd, 16'h00ff);
    unl = 1;
    acc(0, 1, 0, 16'h10c0, 16'h0000);
    acc(0, 0, 0, 16'h10c0, 0);
    chk(rd, 16'h0000);
    unl = 0;
  endtask
  task t_erase;
    ersq(MMD_ERS_SEG, 16'h8400);
    chk({me, mall, 8'h0, mseg}, 16'h8002);
    ersq(MMD_ERS_SEG, 16'hffff);
    chk({me, mall, 8'h0, mseg}, 16'h803f);
    ersq(MMD_ERS_MAIN, 16'h8000);
    chk({14'h0, me, mall}, 16'h0003);
    acc(0, 1, 0, 16'h1040, 16'h0000);
    ersq(MMD_ERS_SEG, 16'h1040);
    acc(0, 0, 0, 16'h1040, 0);
    chk(rd, MMD_ERASED);
    acc(0, 1, 0, 16'h1080, 16'h0000);
    ersq(MMD_ERS_ALL, 16'h0000);
    chk({14'h0, me, mall}, 16'h0003);
    acc(0, 0, 0, 16'h1080, 0);
    chk(rd, MMD_ERASED);
  endtask
  task t_boot_loader;
    txd = 0;
    rxl = 0;
    b_a = 16'h0200;
    b_req = 1;
    tick;
    chkb(txo, 0);
    chkb(vld, 0);
    chkb(bg, 0);
    b_req = 0;
    repeat (5) tick;
    chkb(rxo, 0);
    go = 1;
    tick;
    go = 0;
    tick;
    tick;
    chkb(kbad, 1);
    tick;
    chk({kbad, opn}, 2'b00);
    good = 1;
    go = 1;
    tick;
    go = 0;
    tick;
    tick;
    chkb(opn, 1);
    b_req = 1;
    tick;
    chk(sel, 16'h020);
    chkb(bg, 1);
    b_a = 16'h0c00;
    tick;
    chkb(vld, 0);
    b_req = 0;
  endtask
  task t_rst;
    nrst_i = 0;
    tick;
    nrst_i = 1;
    acc(0, 1, 0, 16'h10c0, 16'h0000);
    chk({lv, opn}, 2'b10);
  endtask
  task give_verdict;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    ref_clk_i = 0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #50000;
    mismatches++;
    give_verdict;
  end
  initial begin
    {nrst_i, c_req, c_we, c_by, c_f, d_req, b_req, ers, unl, go, good} = '0;
    {txd, rxl} = 2'b11;
    {c_a, c_d, b_a, e_a} = '0;
    e_m = MMD_ERS_SEG;
    repeat (16) @(posedge ref_clk_i);
    #1;
    nrst_i = 1;
    t_map;
    t_misc;
    t_lock;
    t_erase;
    t_boot_loader;
    t_rst;
    give_verdict;
  end
endmodule
